// [rtl/sac_top.sv]
// sac_top.sv: serial-to-parallel control of a five-step attenuator with an AXI4-Lite register window
// assumes one 40 MHz system clock; all serial pins arrive from outside its domain and are oversampled
//
// Behaviour
// - pin reset low clears the shift register
// - hold high freezes shifting, ignores clock edges
// - update rising edge copies shift into latches
// - sample serial data on rising clock, LSB first
// - serial out repeats input eight clocks later
// - five binary-weighted steps, 1 to 16 dB
// - each step output active low; all high=reference
// - low bits combine as a binary attenuation code
`timescale 1ns/1ps
`include "sac_regs.svh"

module sac_top
  import sac_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int SHIFT_W = 8,
  parameter int CNT_W = 16
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  // serial link pins
  input wire logic I_SHIFT_CLK,
  input wire logic I_SERIAL_IN,
  input wire logic I_UPDATE,
  input wire logic I_SHIFT_HOLD,
  input wire logic I_PIN_RESET_N,
  output logic O_SERIAL_OUT,
  // attenuation controls
  output logic [SHIFT_W-1:0] O_LATCHED_CONTROL_OUTPUTS,
  output logic O_ATTEN_STEP_1DB_N,
  output logic O_ATTEN_STEP_2DB_N,
  output logic O_ATTEN_STEP_4DB_N,
  output logic O_ATTEN_STEP_8DB_N,
  output logic O_ATTEN_STEP_16DB_N,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  output logic O_S_AXI_AWREADY,
  input wire logic [31:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  output logic O_S_AXI_WREADY,
  output logic [1:0] O_S_AXI_BRESP,
  output logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  output logic O_S_AXI_ARREADY,
  output logic [31:0] O_S_AXI_RDATA,
  output logic [1:0] O_S_AXI_RRESP,
  output logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY
);

  localparam int NPIN = $bits(sac_pins_t);
  localparam logic [NPIN-1:0] PINS_RST = `SAC_PINS_RST;

  // ============================================================
  // pin synchronisers
  sac_pins_t raw_pins;
  sac_pins_t lvl;
  logic [NPIN-1:0] lvl_vec;
  assign raw_pins.rst_n = I_PIN_RESET_N;
  assign raw_pins.hold = I_SHIFT_HOLD;
  assign raw_pins.update = I_UPDATE;
  assign raw_pins.sclk = I_SHIFT_CLK;
  assign raw_pins.sdi = I_SERIAL_IN;
  // three synchroniser flops and a filter flop per pin; a level only moves when stages two and three agree, which rejects one-sample glitches
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic filt_r;
      always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
          s1_r <= PINS_RST[gi];
          s2_r <= PINS_RST[gi];
          s3_r <= PINS_RST[gi];
          filt_r <= PINS_RST[gi];
        end else begin
          s1_r <= raw_pins[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            filt_r <= s3_r;
          end
        end
      end
      assign lvl_vec[gi] = filt_r;
    end
  endgenerate

  assign lvl = sac_pins_t'(lvl_vec);

  // ============================================================
  // edge detection on the filtered clock and strobe
  logic sclk_d_r;
  logic upd_d_r;
  logic sclk_rise;
  logic upd_rise;
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      sclk_d_r <= 1'b0;
      upd_d_r <= 1'b0;
    end else begin
      sclk_d_r <= lvl.sclk;
      upd_d_r <= lvl.update;
    end
  end
  // data and clock share the same filter latency, so data is taken at the same delay as the clock edge
  assign sclk_rise = lvl.sclk & ~sclk_d_r;
  assign upd_rise = lvl.update & ~upd_d_r;

  // ============================================================
  // software control
  logic ctrl_freeze_r;
  logic hold_eff;
  // software freeze acts like the hold pin, so a board without that pin can still lock the register
  assign hold_eff = lvl.hold | ctrl_freeze_r;

  // ============================================================
  // shift register and chained serial output
  logic [SHIFT_W-1:0] shift_r;
  logic sdo_r;
  logic shift_take;
  assign shift_take = sclk_rise & lvl.rst_n & ~hold_eff;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      shift_r <= `SAC_SHIFT_RST;
    end else if (!lvl.rst_n) begin
      shift_r <= `SAC_SHIFT_RST;
    end else if (shift_take) begin
      shift_r <= {lvl.sdi, shift_r[SHIFT_W-1:1]};
    end
  end

  // the bit leaving the bottom entered SHIFT_W edges earlier, giving the cascade delay
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      sdo_r <= `SAC_SDO_RST;
    end else if (!lvl.rst_n) begin
      sdo_r <= `SAC_SDO_RST;
    end else if (shift_take) begin
      sdo_r <= shift_r[0];
    end
  end

  assign O_SERIAL_OUT = sdo_r;

  // ============================================================
  // output latches
  logic [SHIFT_W-1:0] latch_r;
  // only an update edge moves the latches; pin reset and shifting leave the applied attenuation alone
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      latch_r <= `SAC_LATCH_RST;
    end else if (upd_rise && lvl.rst_n) begin
      latch_r <= shift_r;
    end
  end

  // bits 0..4 drive the 1, 2, 4, 8, 16 dB steps directly, low inserts the step
  assign O_LATCHED_CONTROL_OUTPUTS = latch_r;
  assign O_ATTEN_STEP_1DB_N = latch_r[0];
  assign O_ATTEN_STEP_2DB_N = latch_r[1];
  assign O_ATTEN_STEP_4DB_N = latch_r[2];
  assign O_ATTEN_STEP_8DB_N = latch_r[3];
  assign O_ATTEN_STEP_16DB_N = latch_r[4];

  // ============================================================
  // activity counters, wrap silently
  logic [CNT_W-1:0] upd_cnt_r;
  logic [CNT_W-1:0] edge_cnt_r;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      upd_cnt_r <= '0;
    end else if (upd_rise && lvl.rst_n) begin
      upd_cnt_r <= upd_cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      edge_cnt_r <= '0;
    end else if (shift_take) begin
      edge_cnt_r <= edge_cnt_r + CNT_W'(1);
    end
  end

  // ============================================================
  // AXI4-Lite write channel
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  // both address and data held, no answer yet: perform the write
  assign wr_fire = ~awready_r & ~wready_r & ~bvalid_r;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      awready_r <= 1'b1;
    end else if (I_S_AXI_AWVALID && awready_r) begin
      awready_r <= 1'b0;
    end else if (bvalid_r && I_S_AXI_BREADY) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      waddr_r <= '0;
    end else if (I_S_AXI_AWVALID && awready_r) begin
      waddr_r <= I_S_AXI_AWADDR;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      wready_r <= 1'b1;
    end else if (I_S_AXI_WVALID && wready_r) begin
      wready_r <= 1'b0;
    end else if (bvalid_r && I_S_AXI_BREADY) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (I_S_AXI_WVALID && wready_r) begin
      wdata_r <= I_S_AXI_WDATA;
      wstrb_r <= I_S_AXI_WSTRB;
    end
  end

  // response: read-only registers accept writes quietly, unmapped addresses answer with an error
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      bvalid_r <= 1'b0;
      bresp_r <= `SAC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      if (waddr_r == `SAC_OFS_CTRL || waddr_r == `SAC_OFS_STATUS || waddr_r == `SAC_OFS_COUNT) begin
        bresp_r <= `SAC_RESP_OKAY;
      end else begin
        bresp_r <= `SAC_RESP_SLVERR;
      end
    end else if (bvalid_r && I_S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // control register write, honouring the byte lane of the freeze bit
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_freeze_r <= `SAC_CTRL_RST;
    end else if (wr_fire && waddr_r == `SAC_OFS_CTRL && wstrb_r[0]) begin
      ctrl_freeze_r <= wdata_r[`SAC_CTRL_FREEZE_BIT];
    end
  end

  assign O_S_AXI_AWREADY = awready_r;
  assign O_S_AXI_WREADY = wready_r;
  assign O_S_AXI_BVALID = bvalid_r;
  assign O_S_AXI_BRESP = bresp_r;

  // ============================================================
  // AXI4-Lite read channel
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  sac_status_t status;
  logic [31:0] rd_word;
  logic rd_hit;
  assign status.pins = lvl;
  assign status.latched = latch_r;
  assign status.shift = shift_r;
  // read mux; status is a snapshot taken at the address handshake
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (I_S_AXI_ARADDR == `SAC_OFS_CTRL) begin
      rd_word[`SAC_CTRL_FREEZE_BIT] = ctrl_freeze_r;
    end else if (I_S_AXI_ARADDR == `SAC_OFS_STATUS) begin
      rd_word[`SAC_STAT_PINS_LSB +: NPIN] = status.pins;
      rd_word[`SAC_STAT_LATCH_LSB +: SHIFT_W] = status.latched;
      rd_word[`SAC_STAT_SHIFT_LSB +: SHIFT_W] = status.shift;
    end else if (I_S_AXI_ARADDR == `SAC_OFS_COUNT) begin
      rd_word[`SAC_CNT_UPD_LSB +: CNT_W] = upd_cnt_r;
      rd_word[`SAC_CNT_EDGE_LSB +: CNT_W] = edge_cnt_r;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      arready_r <= 1'b1;
    end else if (I_S_AXI_ARVALID && arready_r) begin
      arready_r <= 1'b0;
    end else if (rvalid_r && I_S_AXI_RREADY) begin
      arready_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `SAC_RESP_OKAY;
    end else if (I_S_AXI_ARVALID && arready_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
    end else if (rvalid_r && I_S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign O_S_AXI_ARREADY = arready_r;
  assign O_S_AXI_RVALID = rvalid_r;
  assign O_S_AXI_RDATA = rdata_r;
  assign O_S_AXI_RRESP = rresp_r;

endmodule : sac_top

// [rtl/sac_regs.svh]
// sac_regs.svh: offsets, field positions, reset values and counts of the serial attenuator control block
// assumes a 32-bit AXI4-Lite register window, one aligned word per register
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ============================================================
// register byte offsets
`define SAC_OFS_CTRL 4'h0
`define SAC_OFS_STATUS 4'h4
`define SAC_OFS_COUNT 4'h8

// ============================================================
// control register fields
`define SAC_CTRL_FREEZE_BIT 0
`define SAC_CTRL_RST 1'h0

// ============================================================
// status register fields
`define SAC_STAT_SHIFT_LSB 0
`define SAC_STAT_LATCH_LSB 8
`define SAC_STAT_PINS_LSB 16

// ============================================================
// count register fields
`define SAC_CNT_UPD_LSB 0
`define SAC_CNT_EDGE_LSB 16

// ============================================================
// reset values
`define SAC_SHIFT_RST 8'h00
`define SAC_LATCH_RST 8'hff
`define SAC_PINS_RST 5'h10
`define SAC_SDO_RST 1'h0

// ============================================================
// bus answers
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

// [rtl/sac_pkg.sv]
// sac_pkg.sv: types shared by the serial attenuator control block
// assumes sac_regs.svh is available for the numeric constants
package sac_pkg;

  // ============================================================
  // pin levels after synchronisation, one bit each
  typedef struct packed {
    logic rst_n;
    logic hold;
    logic update;
    logic sclk;
    logic sdi;
  } sac_pins_t;

  // ============================================================
  // fields shown in the status register
  typedef struct packed {
    sac_pins_t pins;
    logic [7:0] latched;
    logic [7:0] shift;
  } sac_status_t;

endpackage : sac_pkg

// [dv/sac_checker_properties.sv]
// sac_checker: port-level timing checks for sac_top
// assumes binding into sac_top; raw pin events reach the logic a few cycles late
`timescale 1ns/1ps
module sac_checker #(
  parameter int SHIFT_W = 8
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_SHIFT_CLK,
  input wire logic I_UPDATE,
  input wire logic I_SHIFT_HOLD,
  input wire logic I_PIN_RESET_N,
  input wire logic O_SERIAL_OUT,
  input wire logic [SHIFT_W-1:0] O_LATCHED_CONTROL_OUTPUTS,
  input wire logic I_S_AXI_ARVALID,
  input wire logic O_S_AXI_ARREADY,
  input wire logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY,
  input wire logic [31:0] O_S_AXI_RDATA
);
  // ============================================================
  // event ages
  logic sclk_q, upd_q;
  logic [3:0] sclk_a, upd_a, rel_a, low_c, quiet_c;

  function automatic logic [3:0] inc(input logic [3:0] c);
    return (c == 4'hf) ? c : c + 4'h1;
  endfunction : inc

  // last pin levels, for raw rising edges
  always_ff @(posedge I_CLK) begin
    sclk_q <= I_SHIFT_CLK;
    upd_q <= I_UPDATE;
  end

  // ages saturate so an old event never looks fresh; reset counts as fresh to stay lenient
  always_ff @(posedge I_CLK) begin
    sclk_a <= (I_SRST || (I_SHIFT_CLK && !sclk_q)) ? 4'h0 : inc(sclk_a);
    upd_a <= (I_SRST || (I_UPDATE && !upd_q)) ? 4'h0 : inc(upd_a);
    rel_a <= (I_SRST || !I_PIN_RESET_N) ? 4'h0 : inc(rel_a);
  end

  // run lengths of pin reset low and of a held shifter
  always_ff @(posedge I_CLK) begin
    low_c <= (I_SRST || I_PIN_RESET_N) ? 4'h0 : inc(low_c);
    quiet_c <= (I_SRST || !I_SHIFT_HOLD || !I_PIN_RESET_N) ? 4'h0 : inc(quiet_c);
  end

  // ============================================================
  // properties
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  a_latch_cause: assert property ($changed(O_LATCHED_CONTROL_OUTPUTS) |-> upd_a <= 4'h8)
    else $error("latches moved without update");
  a_latch_pin_rst: assert property (low_c >= 4'h8 |-> $stable(O_LATCHED_CONTROL_OUTPUTS))
    else $error("pin reset moved latches");
  a_hold_freeze: assert property (quiet_c >= 4'h8 |-> $stable(O_SERIAL_OUT))
    else $error("shifted while held");
  a_pin_rst_clear: assert property (low_c >= 4'h8 |-> !O_SERIAL_OUT)
    else $error("serial out not cleared");
  a_sout_cause: assert property ($changed(O_SERIAL_OUT) |-> sclk_a <= 4'h8 || rel_a <= 4'h8)
    else $error("serial out moved without clock");
  a_read_answer: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID && !O_S_AXI_ARREADY)
    else $error("read answer late");
  a_rdata_stands: assert property (O_S_AXI_RVALID && !I_S_AXI_RREADY |=> O_S_AXI_RVALID && $stable(O_S_AXI_RDATA))
    else $error("read data dropped");
  a_one_read: assert property (O_S_AXI_RVALID |-> !O_S_AXI_ARREADY)
    else $error("second read accepted");
endmodule : sac_checker

bind sac_top sac_checker #(.SHIFT_W(SHIFT_W)) sac_checker_inst (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_SHIFT_CLK(I_SHIFT_CLK), .I_UPDATE(I_UPDATE),
  .I_SHIFT_HOLD(I_SHIFT_HOLD), .I_PIN_RESET_N(I_PIN_RESET_N), .O_SERIAL_OUT(O_SERIAL_OUT),
  .O_LATCHED_CONTROL_OUTPUTS(O_LATCHED_CONTROL_OUTPUTS), .I_S_AXI_ARVALID(I_S_AXI_ARVALID),
  .O_S_AXI_ARREADY(O_S_AXI_ARREADY), .O_S_AXI_RVALID(O_S_AXI_RVALID), .I_S_AXI_RREADY(I_S_AXI_RREADY),
  .O_S_AXI_RDATA(O_S_AXI_RDATA)
);

// [dv/sac_host.sv]
// sac_host: behavioural controller on the serial pins
// assumes the bench calls its tasks; pins move just after a rising i_clk
`timescale 1ns/1ps
module sac_host (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_upd,
  output logic o_hold,
  output logic o_rst_n
);
  // ============================================================
  // pin sequencing
  // idle levels; the link clock stands low between frames
  initial begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_upd = 1'b0;
    o_hold = 1'b0;
    o_rst_n = 1'b1;
  end

  // one 200 ns link period, data set half a period ahead
  task automatic send_bit(input logic b);
    @(posedge i_clk);
    o_sclk <= 1'b0;
    o_sdi <= b;
    repeat (4) @(posedge i_clk);
    o_sclk <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask : send_bit

  // data no longer valid after a frame, so show its inverse
  task automatic end_frame;
    @(posedge i_clk);
    o_sclk <= 1'b0;
    o_sdi <= ~o_sdi;
  endtask : end_frame

  // eight-bit word, lowest bit first
  task automatic send_word(input logic [7:0] w);
    for (int i = 0; i < 8; i++) send_bit(w[i]);
    end_frame();
  endtask : send_word

  // update strobe, then time for the latches to follow
  task automatic pulse_update;
    @(posedge i_clk);
    o_upd <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_upd <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : pulse_update

  // hold and pin reset, given time to pass the input filters
  task automatic set_pins(input logic h, input logic r);
    @(posedge i_clk);
    o_hold <= h;
    o_rst_n <= r;
    repeat (8) @(posedge i_clk);
  endtask : set_pins
endmodule : sac_host

// [dv/tb_serial_attenuator_control.sv]
// tb: self-checking bench for sac_top
// assumes sac_host on the serial pins; this module is the AXI4-Lite master
`timescale 1ns/1ps
`include "sac_regs.svh"
module tb_serial_attenuator_control;
  logic clk, srst, awv, wv, bready, arv, rready, sclk, sdi, upd, hold, rst_n;
  logic sout, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] latched;
  wire [4:0] steps;
  int n_mismatch, n_compared;

  // ============================================================
  // clock, design and controller
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  sac_top sac_top_inst (
    .I_CLK(clk), .I_SRST(srst), .I_SHIFT_CLK(sclk), .I_SERIAL_IN(sdi), .I_UPDATE(upd),
    .I_SHIFT_HOLD(hold), .I_PIN_RESET_N(rst_n), .O_SERIAL_OUT(sout), .O_LATCHED_CONTROL_OUTPUTS(latched),
    .O_ATTEN_STEP_1DB_N(steps[0]), .O_ATTEN_STEP_2DB_N(steps[1]), .O_ATTEN_STEP_4DB_N(steps[2]),
    .O_ATTEN_STEP_8DB_N(steps[3]), .O_ATTEN_STEP_16DB_N(steps[4]), .I_S_AXI_AWADDR(awaddr),
    .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awready), .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(wstrb),
    .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wready), .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid),
    .I_S_AXI_BREADY(bready), .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arready),
    .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready)
  );

  sac_host sac_host_inst (
    .i_clk(clk), .o_sclk(sclk), .o_sdi(sdi), .o_upd(upd), .o_hold(hold), .o_rst_n(rst_n)
  );

  // ============================================================
  // checking and bus tasks
  task automatic give_verdict;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    cmp(32'(bresp), 32'(er));
  endtask : wr

  // read: ready raised late so the answer must stand
  task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    d = rdata;
    rready <= 1'b0;
    cmp(32'(rresp), 32'(er));
  endtask : rd

  // ============================================================
  // scenarios
  // freeze bit reads back and blocks shifting; its write needs byte lane 0; unmapped place refused
  task automatic t_regs;
    logic [31:0] d;
    wr(`SAC_OFS_CTRL, 32'h1, `SAC_RESP_OKAY);
    rd(`SAC_OFS_CTRL, `SAC_RESP_OKAY, d);
    cmp(d, 32'h1);
    sac_host_inst.send_word(8'h5a);
    rd(`SAC_OFS_STATUS, `SAC_RESP_OKAY, d);
    cmp(32'(d[7:0]), 32'h0);
    wr(`SAC_OFS_CTRL, 32'h0, `SAC_RESP_OKAY);
    wstrb <= 4'he;
    wr(`SAC_OFS_CTRL, 32'h1, `SAC_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`SAC_OFS_CTRL, `SAC_RESP_OKAY, d);
    cmp(d, 32'h0);
    wr(4'hc, 32'h1, `SAC_RESP_SLVERR);
    rd(4'hc, `SAC_RESP_SLVERR, d);
    cmp(d, 32'h0);
  endtask : t_regs

  // each single step, then a mixed code
  task automatic t_steps;
    logic [7:0] w;
    for (int k = 0; k < 6; k++) begin
      w = (k < 5) ? ~(8'h01 << k) : 8'h35;
      sac_host_inst.send_word(w);
      sac_host_inst.pulse_update();
      cmp(32'(latched), 32'(w));
      cmp(32'(steps), 32'(w[4:0]));
    end
  endtask : t_steps

  // second word pushes the first out, bit by bit
  task automatic t_serial;
    logic [7:0] a = 8'hc6;
    logic [7:0] b = 8'h3b;
    logic [31:0] d;
    sac_host_inst.send_word(a);
    // each frame bit returns the previous word's bit, so the link clock keeps its period
    for (int i = 0; i < 8; i++) begin
      sac_host_inst.send_bit(b[i]);
      if (i > 0) cmp(32'(sout), 32'(a[i-1]));
    end
    sac_host_inst.end_frame();
    repeat (2) @(posedge clk);
    cmp(32'(sout), 32'(a[7]));
    rd(`SAC_OFS_STATUS, `SAC_RESP_OKAY, d);
    cmp(32'(d[7:0]), 32'(b));
    cmp(32'(latched), 32'h35);
  endtask : t_serial

  // hold pin, then pin reset under hold with an ignored update
  task automatic t_pin_reset;
    logic [31:0] d;
    sac_host_inst.set_pins(1'b1, 1'b1);
    sac_host_inst.send_word(8'h81);
    rd(`SAC_OFS_STATUS, `SAC_RESP_OKAY, d);
    cmp(32'(d[7:0]), 32'h3b);
    sac_host_inst.set_pins(1'b1, 1'b0);
    sac_host_inst.pulse_update();
    rd(`SAC_OFS_STATUS, `SAC_RESP_OKAY, d);
    cmp(32'(d[7:0]), 32'h0);
    cmp(32'(d[20:16]), 32'h08);
    cmp(32'(sout), 32'h0);
    cmp(32'(latched), 32'h35);
    sac_host_inst.set_pins(1'b0, 1'b1);
    sac_host_inst.pulse_update();
    cmp(32'(steps), 32'h0);
    // seven accepted updates, 64 accepted shift edges over the whole run
    rd(`SAC_OFS_COUNT, `SAC_RESP_OKAY, d);
    cmp(d, 32'h0040_0007);
  endtask : t_pin_reset

  // ============================================================
  // main sequence and watchdog
  initial begin
    srst = 1'b1;
    {awv, wv, bready, arv, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    cmp(32'(latched), 32'hff);
    t_regs();
    t_steps();
    t_serial();
    t_pin_reset();
    give_verdict();
  end

  // the run needs about 850 cycles
  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_serial_attenuator_control
